// [mck_memory_checker.sv]
// Memory checker: 32-bit signature compressor, 16 data bits in parallel, with compare
`timescale 1ns/1ps
`default_nettype none

module mck_memory_checker
    import mck_pkg::*;
(
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    // Configuration
    input  wire mck_cfg_s         i_cfg,
    // Control
    input  wire logic             i_start,
    input  wire logic             i_irq_clr,
    // Data stream
    input  wire logic             i_valid,
    input  wire logic [DAT_W-1:0] i_data,
    // Results
    output logic [SIG_W-1:0]      o_sig,
    output logic [SIG_W-1:0]      o_result,
    output logic                  o_done,
    output logic                  o_match,
    output logic                  o_err,
    output logic                  o_irq,
    output logic                  o_busy
);

    mck_state_s s_q;
    mck_state_s s_d;

    // One bit-serial step per data bit, msb first, unrolled combinationally
    function automatic logic [SIG_W-1:0] crc_step(
        input logic [SIG_W-1:0] sig,
        input logic [DAT_W-1:0] dat,
        input logic [SIG_W-1:0] poly
    );
        logic [SIG_W-1:0] r;
        logic             fb;
        r = sig;
        for (int i = DAT_W - 1; i >= 0; i--) begin
            fb = r[SIG_W-1] ^ dat[i];
            r  = {r[SIG_W-2:0], 1'b0} ^ (fb ? poly : '0);
        end
        return r;
    endfunction

    logic [SIG_W-1:0] next_sig;
    assign next_sig = crc_step(s_q.sig, i_data, i_cfg.poly);

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        unique case (s_q.state)
            MCK_IDLE, MCK_DONE: begin
                if (i_start) begin
                    s_d.sig   = i_cfg.seed;
                    s_d.cnt   = i_cfg.block_len;
                    s_d.busy  = (i_cfg.block_len != CNT_RST);
                    s_d.state = (i_cfg.block_len != CNT_RST) ? MCK_RUN
                                                             : MCK_IDLE;
                end
            end
            MCK_RUN: begin
                if (i_valid) begin
                    s_d.sig = next_sig;
                    s_d.cnt = s_q.cnt - 16'h0001;
                    if (s_q.cnt == 16'h0001) begin
                        // Result latched so the live LFSR stays readable
                        s_d.result = next_sig;
                        s_d.done   = 1'b1;
                        s_d.busy   = 1'b0;
                        s_d.match  = (next_sig == i_cfg.expect_sig);
                        s_d.err    = (next_sig != i_cfg.expect_sig);
                        s_d.state  = MCK_DONE;
                    end
                end
            end
            default: s_d.state = MCK_IDLE;
        endcase
        // Set wins over clear so a late mismatch is never lost
        if (i_irq_clr) begin
            s_d.irq = 1'b0;
        end
        if (s_d.done && s_d.err && i_cfg.irq_en) begin
            s_d.irq = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q.state  <= MCK_IDLE;
            s_q.sig    <= SIG_RST;
            s_q.cnt    <= CNT_RST;
            s_q.result <= SIG_RST;
            s_q.done   <= 1'b0;
            s_q.match  <= 1'b0;
            s_q.err    <= 1'b0;
            s_q.irq    <= 1'b0;
            s_q.busy   <= 1'b0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_sig    = s_q.sig;
    assign o_result = s_q.result;
    assign o_done   = s_q.done;
    assign o_match  = s_q.match;
    assign o_err    = s_q.err;
    assign o_irq    = s_q.irq;
    assign o_busy   = s_q.busy;

    // Assertions
    // Last accepted word of a block: compare, result and irq act here
    logic last_word;
    assign last_word = i_ce && s_q.state == MCK_RUN && i_valid
                       && s_q.cnt == 16'h0001;

    sequence last_word_s;
        last_word;
    endsequence

    chk_sig_update: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && s_q.state == MCK_RUN && i_valid)
        |=> s_q.sig == $past(next_sig))
        else $error("signature not updated on word");

    chk_sig_hold: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && s_q.state == MCK_RUN && !i_valid) |=> $stable(s_q.sig))
        else $error("signature moved without data");

    // No taps: the word only shifts the register left by its width
    chk_poly_zero: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && s_q.state == MCK_RUN && i_valid && i_cfg.poly == '0)
        |=> s_q.sig == {$past(s_q.sig[15:0]), 16'h0000})
        else $error("zero polynomial step wrong");

    chk_cnt_done: assert property (
        @(posedge i_clk) disable iff (i_rst)
        last_word_s |=> o_done && !o_busy && o_result == o_sig)
        else $error("block did not finish on count");

    chk_done_cause: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_done) |-> $past(s_q.cnt) == 16'h0001)
        else $error("done without count reached");

    chk_done_pulse: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (o_done && i_ce) |=> !o_done)
        else $error("done stood longer than one cycle");

    chk_busy_state: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_busy == (s_q.state == MCK_RUN))
        else $error("busy disagrees with running state");

    chk_start_run: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_start && s_q.state != MCK_RUN
         && i_cfg.block_len != CNT_RST)
        |=> o_busy && s_q.cnt == $past(i_cfg.block_len))
        else $error("start did not begin a block");

    chk_len_zero: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_start && s_q.state != MCK_RUN
         && i_cfg.block_len == CNT_RST)
        |=> !o_busy)
        else $error("zero length block started");

    // While running, a cycle without valid data must hold the count and keep busy set
    chk_run_refuse: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && s_q.state == MCK_RUN && !i_valid)
        |=> $stable(s_q.cnt) && o_busy)
        else $error("count moved without data");

    chk_idle_ignore: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && s_q.state != MCK_RUN && !i_start)
        |=> $stable(s_q.sig) && $stable(s_q.cnt))
        else $error("data absorbed outside a block");

    // Enable low must hold every field, flags included
    chk_ce_freeze: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !i_ce |=> $stable(s_q))
        else $error("state moved with clock enable low");

    chk_irq_raise: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (last_word_s ##0 (next_sig != i_cfg.expect_sig && i_cfg.irq_en))
        |=> o_irq)
        else $error("mismatch did not raise irq");

    chk_irq_cause: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_irq) |-> o_done && o_err && $past(i_cfg.irq_en))
        else $error("irq raised without enabled mismatch");

    chk_irq_hold: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (o_irq && !i_irq_clr) |=> o_irq)
        else $error("irq dropped without clear");

    chk_irq_clear: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_irq_clr && !last_word) |=> !o_irq)
        else $error("irq not cleared");

    chk_cmp_result: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_done |-> (o_match == (o_result == $past(i_cfg.expect_sig)))
        && (o_err == !o_match))
        else $error("compare result wrong");

    chk_result_hold: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && !last_word)
        |=> $stable(o_result) && $stable(o_match) && $stable(o_err))
        else $error("result changed outside block end");

    chk_seed_load: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_start && s_q.state != MCK_RUN)
        |=> s_q.sig == $past(i_cfg.seed) && s_q.cnt == $past(i_cfg.block_len))
        else $error("seed or length not loaded");

endmodule : mck_memory_checker

`default_nettype wire

// [mck_pkg.sv]
// Package for the memory checker: constants and carrier types
package mck_pkg;
    localparam int unsigned SIG_W = 32;
    localparam int unsigned DAT_W = 16;
    localparam int unsigned CNT_W = 16;
    localparam logic [SIG_W-1:0] SIG_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    typedef enum logic [1:0] {
        MCK_IDLE,
        MCK_RUN,
        MCK_DONE
    } mck_state_e;

    typedef struct packed {
        logic [SIG_W-1:0] poly;
        logic [SIG_W-1:0] seed;
        logic [SIG_W-1:0] expect_sig;
        logic [CNT_W-1:0] block_len;
        logic             irq_en;
    } mck_cfg_s;

    typedef struct packed {
        mck_state_e       state;
        logic [SIG_W-1:0] sig;
        logic [CNT_W-1:0] cnt;
        logic [SIG_W-1:0] result;
        logic             done;
        logic             match;
        logic             err;
        logic             irq;
        logic             busy;
    } mck_state_s;
endpackage : mck_pkg

// [memory_crc_checker_test.sv]
// Self-checking testbench for the memory signature checker
`timescale 1ns/1ps
`default_nettype none
module memory_crc_checker_test;
    import mck_pkg::*;
    logic             i_clk = 1'b0;
    logic             i_rst = 1'b1;
    logic             i_ce = 1'b1;
    mck_cfg_s         i_cfg = '0;
    logic             i_start = 1'b0;
    logic             i_irq_clr = 1'b0;
    logic             i_valid = 1'b0;
    logic [DAT_W-1:0] i_data = 16'h0000;
    logic [SIG_W-1:0] o_sig, o_result;
    logic             o_done, o_match, o_err, o_irq, o_busy;
    int               errors = 0;
    int               tests_run = 0;
    int               cycles = 0;

    mck_memory_checker uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_cfg(i_cfg), .i_start(i_start), .i_irq_clr(i_irq_clr),
        .i_valid(i_valid), .i_data(i_data), .o_sig(o_sig),
        .o_result(o_result), .o_done(o_done), .o_match(o_match),
        .o_err(o_err), .o_irq(o_irq), .o_busy(o_busy));

    always #20 i_clk = ~i_clk;

    // Generous ceiling: the whole run needs well under 100 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [SIG_W-1:0] seen,
                         input logic [SIG_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // MSB-first step, one whole word per update
    function automatic logic [SIG_W-1:0] step(input logic [SIG_W-1:0] s,
        input logic [DAT_W-1:0] d, input logic [SIG_W-1:0] p);
        for (int i = DAT_W-1; i >= 0; i--)
            s = (s[31] ^ d[i]) ? ((s << 1) ^ p) : (s << 1);
        return s;
    endfunction

    task automatic run_block(input logic [SIG_W-1:0] seed, poly, input int n,
                             input logic ok, input logic ien);
        logic [SIG_W-1:0] s;
        logic [DAT_W-1:0] w;
        s = seed;
        for (int k = 0; k < n; k++)
            s = step(s, 16'hA5C3 ^ 16'(k * 16'h1357), poly);
        i_cfg = '{poly: poly, seed: seed, expect_sig: ok ? s : ~s,
                  block_len: 16'(n), irq_en: ien};
        i_start = 1'b1;
        tick();
        i_start = 1'b0;
        check("busy", o_busy, 1);
        check("seed", o_sig, seed);
        s = seed;
        for (int k = 0; k < n; k++) begin
            w = 16'hA5C3 ^ 16'(k * 16'h1357);
            s = step(s, w, poly);
            i_valid = 1'b1;
            i_data = w;
            tick();
            i_valid = 1'b0;
            if (k < n - 1) begin
                check("sig", o_sig, s);
                tick();
            end
        end
        check("done", o_done, 1);
        check("busy end", o_busy, 0);
        check("result", o_result, s);
        check("match", o_match, ok);
        check("err", o_err, !ok);
        check("irq", o_irq, ien & !ok);
        tick();
        check("done pulse", o_done, 0);
        $display("block of %0d words finished", n);
    endtask

    // Start while busy, frozen enable, back-to-back words, irq race
    task automatic refuse_test();
        logic [SIG_W-1:0] s1;
        logic [SIG_W-1:0] s2;
        s1 = step(32'h5A5A_0F0F, 16'h1234, 32'h04C1_1DB7);
        s2 = step(s1, 16'h8001, 32'h04C1_1DB7);
        i_cfg = '{poly: 32'h04C1_1DB7, seed: 32'h5A5A_0F0F,
                  expect_sig: ~s2, block_len: 16'h0002, irq_en: 1'b1};
        i_start = 1'b1;
        tick();
        i_cfg.seed = 32'h0000_0000;
        tick();
        i_start = 1'b0;
        check("start busy", o_sig, 32'h5A5A_0F0F);
        check("busy kept", o_busy, 1);
        i_ce = 1'b0;
        i_valid = 1'b1;
        i_data = 16'h1234;
        tick();
        check("ce frozen", o_sig, 32'h5A5A_0F0F);
        i_ce = 1'b1;
        tick();
        check("ce resume", o_sig, s1);
        i_data = 16'h8001;
        i_irq_clr = 1'b1;
        tick();
        check("back to back", o_result, s2);
        check("race done", o_done, 1);
        check("race err", o_err, 1);
        check("irq set wins", o_irq, 1);
        i_irq_clr = 1'b0;
        i_data = 16'hFFFF;
        tick();
        check("valid ignored", o_sig, s2);
        i_valid = 1'b0;
        i_irq_clr = 1'b1;
        tick();
        i_irq_clr = 1'b0;
        check("irq cleared", o_irq, 0);
        $display("refusal and race test finished");
    endtask

    // Reset in mid-block clears the register, the counter and the flags
    task automatic reset_test();
        i_cfg = '{poly: 32'h04C1_1DB7, seed: 32'hFFFF_FFFF,
                  expect_sig: 32'h0000_0000,
                  block_len: 16'h0003, irq_en: 1'b1};
        i_start = 1'b1;
        tick();
        i_start = 1'b0;
        i_valid = 1'b1;
        i_data = 16'hA5C3;
        tick();
        i_valid = 1'b0;
        check("mid busy", o_busy, 1);
        i_rst = 1'b1;
        tick();
        tick();
        i_rst = 1'b0;
        check("rst sig", o_sig, 0);
        check("rst busy", o_busy, 0);
        check("rst result", o_result, 0);
        check("rst err", o_err, 0);
        i_valid = 1'b1;
        tick();
        i_valid = 1'b0;
        check("rst valid", o_sig, 0);
        $display("mid-run reset test finished");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_rst = 1'b0;
        check("sig rst", o_sig, 0);
        check("irq rst", o_irq, 0);
        $display("reset test finished");
        run_block(32'hFFFF_FFFF, 32'h04C1_1DB7, 3, 1'b1, 1'b1);
        run_block(32'h1234_5678, 32'h1EDC_6F41, 1, 1'b0, 1'b1);
        i_irq_clr = 1'b1;
        tick();
        i_irq_clr = 1'b0;
        check("irq clr", o_irq, 0);
        run_block(32'h0000_0001, 32'h8000_0001, 4, 1'b0, 1'b0);
        i_cfg.block_len = 16'h0000;
        i_start = 1'b1;
        tick();
        i_start = 1'b0;
        check("len zero", o_busy, 0);
        $display("refusal test finished");
        run_block(32'h0123_4567, 32'h0000_0000, 2, 1'b1, 1'b0);
        refuse_test();
        reset_test();
        tally_and_finish();
    end
endmodule // memory_crc_checker_test
`default_nettype wire
